//--- hwm_alert.sv
// Purpose: temperature interrupt modes, status and masks, reset pin and board test of the monitor
// Assumes: one hclk domain; pins sampled through three flops; AHB-Lite slave, single word transfers
// Notes: reads take one wait state, writes none; every response is OKAY
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module hwm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // a bit moves only once the second and third stage agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q <= ((s2_r ~^ s3_r) & s2_r) | ((s2_r ^ s3_r) & q);
    end
  end
endmodule : hwm_sync

module hwm_alert
  import hwm_pkg::*;
#(
  parameter int RST_CYC = hwm_pkg::RST_PULSE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] temp_result,
  input wire logic temp_valid,
  input wire logic [15:0] volt_fan_events,
  input wire logic chassis_intrusion,
  output logic loop_halted,
  output logic alert_n,
  output logic critical_temp_alarm_n,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  input wire logic tree_test_entry_pin,
  input wire logic [hwm_pkg::NTREE-1:0] tree_pins,
  output logic tree_test_result_pin,
  output logic tree_test_result_oe
);
  import hwm_pkg::*;

  logic [7:0] cfg_r;
  logic [7:0] stat1_r;
  logic [7:0] stat2_r;
  logic [7:0] mask1_r;
  logic [7:0] mask2_r;
  logic [7:0] ext1_r;
  logic [7:0] ext2_r;
  hwm_limits_t lim_r;
  logic low_trip_r;
  logic high_trip_r;
  logic crit_trip_r;
  logic crit_latch_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] idx_r;
  logic [RST_CNT_W-1:0] rst_cnt_r;
  logic [2:0] blank_r;
  logic cfg_written_r;
  logic test_mode_r;
  logic chassis_s;
  logic reset_pin_s;
  logic entry_s;
  logic [NTREE-1:0] tree_s;

  // pins from outside the clock domain
  hwm_sync #(.W(1), .INIT(1'b0)) u_sync_chassis (
    .clk(hclk), .rst_n(hresetn), .d(chassis_intrusion), .q(chassis_s)
  );
  hwm_sync #(.W(1), .INIT(1'b1)) u_sync_rst (
    .clk(hclk), .rst_n(hresetn), .d(reset_pin_i), .q(reset_pin_s)
  );
  hwm_sync #(.W(1), .INIT(1'b0)) u_sync_entry (
    .clk(hclk), .rst_n(hresetn), .d(tree_test_entry_pin), .q(entry_s)
  );
  hwm_sync #(.W(NTREE), .INIT({NTREE{1'b1}})) u_sync_tree (
    .clk(hclk), .rst_n(hresetn), .d(tree_pins), .q(tree_s)
  );

  // bus decode
  wire addr_ph = hsel & htrans[1] & hready;
  wire wr_fire = wr_pend_r & hready;
  wire rd_fire = rd_pend_r & ~hreadyout;
  wire wr_cfg = wr_fire && (idx_r == IDX_CFG);
  wire rd_stat1 = rd_fire && (idx_r == IDX_STAT1);
  wire rd_stat2 = rd_fire && (idx_r == IDX_STAT2);
  wire rd_ext1 = rd_fire && (idx_r == IDX_EXT1);
  wire [7:0] wbyte = hwdata[7:0];

  // reset pin: driving while the pulse counter runs, input otherwise
  wire rst_driving = (rst_cnt_r != '0);
  wire rst_start = wr_cfg & wbyte[CFG_RST_OUT_BIT] & mask2_r[MASK2_RST_EN_BIT]; // RQ17 RQ18
  wire soft_rst = ~reset_pin_s & ~rst_driving & (blank_r == 3'h0) & ~rst_start; // RQ19

  // monitoring loop runs unless the alert clear bit is set or board test mode has been entered
  wire loop_run = ~cfg_r[CFG_INT_CLR_BIT] & ~test_mode_r; // RQ16
  wire conv = temp_valid & loop_run; // RQ24
  wire one_time = (hwm_tmode_t'(ext2_r[EXT2_MODE_BIT]) == HWM_ONE_TIME);

  // comparisons in nine signed bits so the offset sums cannot wrap
  wire signed [8:0] t9 = $signed({temp_result[7], temp_result}); // RQ22
  wire signed [8:0] hi9 = $signed({lim_r.high[7], lim_r.high});
  wire signed [8:0] lo9 = $signed({lim_r.low[7], lim_r.low});
  wire signed [8:0] cr9 = $signed({lim_r.crit[7], lim_r.crit});
  wire signed [8:0] hy9 = $signed({6'h00, lim_r.hyst}); // RQ23
  wire signed [8:0] lo_rel = lo9 + hy9;
  wire signed [8:0] hi_rel = hi9 - hy9;
  wire signed [8:0] cr_rel = cr9 - hy9;
  wire low_set = t9 <= lo9; // RQ3 RQ6
  wire low_clr = t9 > lo_rel; // RQ3 RQ6
  wire high_set = t9 > hi9; // RQ4 RQ7
  wire high_clr = t9 <= hi_rel; // RQ4 RQ7
  wire crit_set = t9 > cr9; // RQ5 RQ8
  wire crit_clr = t9 <= cr_rel; // RQ5 RQ8

  // one tripped flag per threshold serves both modes: in one-time mode it is the
  // disarm flag, in comparator mode it is the active level
  wire low_nxt = low_set | (low_trip_r & ~low_clr);
  wire high_nxt = high_set | (high_trip_r & ~high_clr);
  wire crit_nxt = crit_set | (crit_trip_r & ~crit_clr);
  wire low_fire = low_set & ~low_trip_r; // RQ3
  wire high_fire = high_set & ~high_trip_r; // RQ4
  wire crit_fire = crit_set & ~crit_trip_r; // RQ5
  wire temp_evt = conv & (one_time ? (low_fire | high_fire) : (low_nxt | high_nxt)); // RQ1 RQ6 RQ7
  wire crit_evt = conv & (one_time ? crit_fire : crit_nxt); // RQ8 RQ12

  // status sources, loop events only while the loop runs
  wire [7:0] ev1 = (volt_fan_events[7:0] & {8{loop_run}} & ~(8'h01 << STAT1_TEMP_BIT))
                   | ({7'h00, temp_evt} << STAT1_TEMP_BIT);
  wire [7:0] ev2 = (volt_fan_events[15:8] & {8{loop_run}} & ~(8'h01 << STAT2_CHASSIS_BIT))
                   | ({7'h00, chassis_s & loop_run} << STAT2_CHASSIS_BIT); // RQ9
  wire [15:0] pending = {stat2_r, stat1_r} & ~{mask2_r, mask1_r}; // RQ10
  wire alert_on = cfg_r[CFG_INT_EN_BIT] & ~cfg_r[CFG_INT_CLR_BIT] & ~test_mode_r & (|pending); // RQ11 RQ14 RQ16

  // read multiplexer; bit 4 of the configuration reads back the running pulse
  wire [7:0] cfg_rd = (cfg_r & ~(8'h01 << CFG_RST_OUT_BIT)) | ({7'h00, rst_driving} << CFG_RST_OUT_BIT);
  wire [7:0] ext1_rd = (ext1_r & ~(8'h01 << EXT1_CRIT_BIT)) | ({7'h00, crit_latch_r} << EXT1_CRIT_BIT);
  wire [7:0] rd_val =
    (idx_r == IDX_CFG) ? cfg_rd :
    (idx_r == IDX_STAT1) ? stat1_r :
    (idx_r == IDX_STAT2) ? stat2_r :
    (idx_r == IDX_MASK1) ? mask1_r :
    (idx_r == IDX_MASK2) ? mask2_r :
    (idx_r == IDX_EXT1) ? ext1_rd :
    (idx_r == IDX_EXT2) ? ext2_r :
    (idx_r == IDX_HIGH_TEMP_SETPOINT) ? lim_r.high :
    (idx_r == IDX_LOW_TEMP_SETPOINT) ? lim_r.low :
    (idx_r == IDX_TCRIT) ? lim_r.crit :
    (idx_r == IDX_HYSTERESIS_OFFSET) ? {5'h00, lim_r.hyst} : 8'h00;

  // bus phases: writes are zero wait, reads hold hreadyout low for one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else begin
      if (addr_ph) begin
        wr_pend_r <= hwrite;
        rd_pend_r <= ~hwrite;
        idx_r <= haddr[IDX_MSB:IDX_LSB];
        hreadyout <= hwrite;
      end else if (hready) begin
        wr_pend_r <= 1'b0;
        rd_pend_r <= 1'b0;
      end else begin
        hreadyout <= 1'b1;
      end
      if (rd_fire) begin
        hrdata <= {24'h000000, rd_val}; // RQ13
      end
    end
  end

  // response is always OKAY; the size is not checked, word transfers assumed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // software registers; the reset pin restores them but leaves setpoints alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= CFG_RST;
      mask1_r <= MASK_RST;
      mask2_r <= MASK_RST;
      ext1_r <= EXT1_RST;
      ext2_r <= EXT2_RST;
    end else if (soft_rst) begin
      cfg_r <= CFG_RST; // RQ19
      mask1_r <= MASK_RST;
      mask2_r <= MASK_RST;
      ext1_r <= EXT1_RST;
      ext2_r <= EXT2_RST;
    end else if (wr_fire) begin
      if (idx_r == IDX_CFG) cfg_r <= wbyte & ~(8'h01 << CFG_RST_OUT_BIT);
      if (idx_r == IDX_MASK1) mask1_r <= wbyte;
      if (idx_r == IDX_MASK2) mask2_r <= wbyte;
      if (idx_r == IDX_EXT1) ext1_r <= wbyte;
      if (idx_r == IDX_EXT2) ext2_r <= wbyte;
    end
  end

  // setpoints and hysteresis
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lim_r <= '{high: HIGH_TEMP_SETPOINT_RST, low: LOW_TEMP_SETPOINT_RST, crit: TCRIT_RST, hyst: HYSTERESIS_OFFSET_RST};
    end else if (wr_fire) begin
      if (idx_r == IDX_HIGH_TEMP_SETPOINT) lim_r.high <= wbyte; // RQ22
      if (idx_r == IDX_LOW_TEMP_SETPOINT) lim_r.low <= wbyte;
      if (idx_r == IDX_TCRIT) lim_r.crit <= wbyte;
      if (idx_r == IDX_HYSTERESIS_OFFSET) lim_r.hyst <= wbyte[2:0]; // RQ23
    end
  end

  // status: read clears, a same-cycle event wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat1_r <= STAT_RST;
      stat2_r <= STAT_RST;
    end else if (soft_rst) begin
      stat1_r <= STAT_RST;
      stat2_r <= STAT_RST;
    end else begin
      stat1_r <= (stat1_r & ~{8{rd_stat1}}) | ev1; // RQ1 RQ10 RQ13
      stat2_r <= (stat2_r & ~{8{rd_stat2}}) | ev2; // RQ13
    end
  end

  // threshold state, advanced only at a finished conversion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_trip_r <= 1'b0;
      high_trip_r <= 1'b0;
      crit_trip_r <= 1'b0;
    end else if (soft_rst) begin
      low_trip_r <= 1'b0;
      high_trip_r <= 1'b0;
      crit_trip_r <= 1'b0;
    end else if (conv) begin
      low_trip_r <= low_nxt; // RQ24
      high_trip_r <= high_nxt;
      crit_trip_r <= crit_nxt;
    end
  end

  // critical alarm latch, cleared by reading extended register 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crit_latch_r <= 1'b0;
    end else if (soft_rst) begin
      crit_latch_r <= 1'b0;
    end else begin
      crit_latch_r <= crit_evt | (crit_latch_r & ~rd_ext1); // RQ2 RQ12
    end
  end

  // reset pulse counter and a short blanking so our own release is not read as a reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_cnt_r <= '0;
      blank_r <= 3'h0;
    end else begin
      if (rst_start) begin
        rst_cnt_r <= RST_CNT_W'(RST_CYC); // RQ18
      end else if (rst_driving) begin
        rst_cnt_r <= rst_cnt_r - 1'b1;
      end
      if (rst_driving) begin
        blank_r <= RST_BLANK_CYC;
      end else if (blank_r != 3'h0) begin
        blank_r <= blank_r - 3'h1;
      end
    end
  end

  // board test entry is possible only until the first configuration write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_written_r <= 1'b0;
      test_mode_r <= 1'b0;
    end else begin
      if (wr_cfg) cfg_written_r <= 1'b1;
      if (entry_s & ~cfg_written_r & ~wr_cfg) test_mode_r <= 1'b1; // RQ20
    end
  end

  // output flops; in test mode the alert and critical alarm outputs let go, the halt output reads halted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_n <= 1'b1;
      critical_temp_alarm_n <= 1'b1;
      loop_halted <= 1'b1;
      reset_pin_o <= 1'b0;
      reset_pin_oe <= 1'b0;
      tree_test_result_pin <= 1'b1;
      tree_test_result_oe <= 1'b0;
    end else begin
      alert_n <= ~alert_on; // RQ11 RQ14
      critical_temp_alarm_n <= ~(crit_latch_r & ~test_mode_r); // RQ12
      loop_halted <= ~loop_run; // RQ16
      reset_pin_o <= 1'b0;
      reset_pin_oe <= rst_start | (rst_driving & (rst_cnt_r != RST_CNT_W'(1))); // RQ17 RQ18
      tree_test_result_pin <= ~(^(~tree_s)); // RQ21
      tree_test_result_oe <= test_mode_r;
    end
  end
endmodule : hwm_alert

`default_nettype wire

//--- hwm_alert_asserts.sv
// Purpose: port-level checks of bus timing, alarm cause, reset pulse and board test of hwm_alert
// Assumes: one hclk domain; sees only the top ports
// Notes: RST_CYC is handed on by the bind so pulse lengths match the instance
`timescale 1ns/1ps
`default_nettype none
module hwm_alert_chk
  import hwm_pkg::*;
#(
  parameter int RST_CYC = 50
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic temp_valid,
  input wire logic loop_halted,
  input wire logic alert_n,
  input wire logic critical_temp_alarm_n,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  input wire logic [hwm_pkg::NTREE-1:0] tree_pins,
  input wire logic tree_test_result_pin,
  input wire logic tree_test_result_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int pulse_cnt_r;
  // length of the current pulse; cleared on release so every pulse is measured alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pulse_cnt_r <= 0;
    else if (reset_pin_oe) pulse_cnt_r <= pulse_cnt_r + 1;
    else pulse_cnt_r <= 0;
  end
  // a read is answered after exactly one wait state
  sequence s_rd_req; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
  property p_rd_wait; s_rd_req |=> s_one_wait; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_halt_quiet; loop_halted && $past(loop_halted) |-> alert_n; endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("alert while loop halted");
  property p_crit_cause; $fell(critical_temp_alarm_n) |-> $past(temp_valid, 2); endproperty
  a_crit_cause: assert property (p_crit_cause) else $error("alarm without conversion");
  property p_pulse_len; $fell(reset_pin_oe) |-> pulse_cnt_r == RST_CYC; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
  property p_pulse_max; pulse_cnt_r <= RST_CYC; endproperty
  a_pulse_max: assert property (p_pulse_max) else $error("reset pulse too long");
  property p_pulse_low; reset_pin_oe |-> !reset_pin_o; endproperty
  a_pulse_low: assert property (p_pulse_low) else $error("reset pin driven high");
  property p_tree_hold; tree_test_result_oe |=> tree_test_result_oe; endproperty
  a_tree_hold: assert property (p_tree_hold) else $error("test mode left");
  property p_tree_par; $stable(tree_pins)[*5] ##0 tree_test_result_oe |-> tree_test_result_pin == ~^tree_pins; endproperty
  a_tree_par: assert property (p_tree_par) else $error("tree result wrong");
endmodule : hwm_alert_chk
bind hwm_alert hwm_alert_chk #(.RST_CYC(RST_CYC)) chk_u (.*);
`default_nettype wire

//--- hwm_alert_bench.sv
// Purpose: self-checking bench of hwm_alert over AHB-Lite
// Assumes: rows are {temp, 0, mode, status bit, alarm}; default setpoints 80/0/100, hysteresis 2
// Notes: reset pulse shortened through RST_CYC
`timescale 1ns/1ps
`default_nettype none
module hwm_alert_bench;
  import hwm_pkg::*;
  localparam int RST_CYC = 50;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, temp_valid = 0, ext_low = 0, intrude = 0, tree_entry = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [7:0] temp = 0;
  logic [15:0] vfe = 0, tree = 16'hffff;
  logic hreadyout, hresp, halted, alert_n, crit_n, rpo, rpoe, rline, chassis, tres, toe;
  int bad_count = 0, checks_done = 0;
  logic [11:0] rows [21] = '{12'h200, 12'h512, 12'h510, 12'h4e0, 12'h653, 12'h650, 12'h620, 12'h651, 12'h002,
    12'h010, 12'h030, 12'hff2, 12'hff6, 12'h026, 12'h034, 12'h516, 12'h4f6, 12'h4e4, 12'h657, 12'h637, 12'h626};
  always #4 hclk = ~hclk;
  hwm_alert #(.RST_CYC(RST_CYC)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .temp_result(temp), .temp_valid(temp_valid), .volt_fan_events(vfe),
    .chassis_intrusion(chassis), .loop_halted(halted), .alert_n(alert_n), .critical_temp_alarm_n(crit_n),
    .reset_pin_i(rline), .reset_pin_o(rpo), .reset_pin_oe(rpoe), .tree_test_entry_pin(tree_entry),
    .tree_pins(tree), .tree_test_result_pin(tres), .tree_test_result_oe(toe));
  hwm_board board_u (.reset_pin_oe(rpoe), .reset_pin_o(rpo), .ext_pull_low(ext_low), .intrude(intrude),
    .reset_line(rline), .chassis_intrusion(chassis));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // bounded wait for hready; a hang ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) bad_count++;
      if (n > 20) print_verdict();
      @(posedge hclk);
    end
  endtask : wait_ready
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata[7:0];
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] x;
    bus(1'b1, idx, wd, x);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk({24'h0, x}, {24'h0, exp});
  endtask : rdc
  task automatic conv(input logic [7:0] t);
    temp <= t;
    temp_valid <= 1'b1;
    @(posedge hclk);
    temp_valid <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : conv
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset
  // main sequence: reset, board test, table rows, then the awkward cases
  initial begin
    logic [11:0] r;
    int n;
    do_reset();
    rdc(IDX_CFG, 8'h08);
    rdc(IDX_EXT1, 8'h44);
    tree_entry <= 1'b1;
    // three sync stages, the sync output flop, the mode flop and the output flop: wait past all of them
    repeat (8) @(posedge hclk);
    chk(toe, 1'b1);
    chk(tres, 1'b1);
    for (int i = 0; i < 16; i++) begin
      tree[i] <= 1'b0;
      repeat (6) @(posedge hclk);
      chk(tres, i[0]);
    end
    tree_entry <= 1'b0;
    tree <= 16'hffff;
    do_reset();
    wr(IDX_CFG, 8'h02);
    tree_entry <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(toe, 1'b0);
    tree_entry <= 1'b0;
    $display("board test done");
    for (int i = 0; i < 21; i++) begin
      r = rows[i];
      wr(IDX_EXT2, {7'h0, r[2]});
      conv(r[11:4]);
      chk(alert_n, !r[1]);
      chk(crit_n, !r[0]);
      // status is read once per fresh conversion, standing in for the long refresh spacing
      rdc(IDX_STAT1, {3'h0, r[1], 4'h0});
      chk(hresp, 1'b0);
      rdc(IDX_EXT1, {7'h22, r[0]});
      repeat (2) @(posedge hclk);
      chk(alert_n, 1'b1);
      chk(crit_n, 1'b1);
    end
    $display("threshold rows done");
    wr(IDX_CFG, 8'h12);
    repeat (2) @(posedge hclk);
    chk(rpoe, 1'b0);
    rdc(IDX_CFG, 8'h02);
    wr(IDX_MASK2, 8'h80);
    wr(IDX_CFG, 8'h12);
    n = 0;
    repeat (RST_CYC + 10) begin
      @(posedge hclk);
      if (rline === 1'b0) n++;
    end
    chk(n, RST_CYC);
    rdc(IDX_CFG, 8'h02);
    $display("reset pulse done");
    wr(IDX_HIGH_TEMP_SETPOINT, 8'h55);
    ext_low <= 1'b1;
    repeat (8) @(posedge hclk);
    ext_low <= 1'b0;
    repeat (6) @(posedge hclk);
    rdc(IDX_CFG, 8'h08);
    rdc(IDX_MASK2, 8'h00);
    rdc(IDX_HIGH_TEMP_SETPOINT, 8'h55);
    chk(halted, 1'b1);
    $display("reset input done");
    wr(IDX_CFG, 8'h0a);
    conv(8'h60);
    chk(alert_n, 1'b1);
    rdc(IDX_STAT1, 8'h00);
    wr(IDX_CFG, 8'h02);
    // the halt output is a flop behind the configuration register: one edge later
    repeat (2) @(posedge hclk);
    chk(halted, 1'b0);
    conv(8'h60);
    chk(alert_n, 1'b0);
    wr(IDX_MASK1, 8'h10);
    repeat (2) @(posedge hclk);
    chk(alert_n, 1'b1);
    rdc(IDX_STAT1, 8'h10);
    wr(IDX_MASK1, 8'h00);
    wr(IDX_CFG, 8'h00);
    intrude <= 1'b1;
    repeat (8) @(posedge hclk);
    intrude <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(alert_n, 1'b1);
    rdc(IDX_STAT2, 8'h10);
    $display("halt, mask and intrusion done");
    print_verdict();
  end
endmodule : hwm_alert_bench
`default_nettype wire

//--- hwm_board.sv
// Purpose: board around the monitor: pulled-up reset line and intrusion detector
// Assumes: open-drain line, nobody drives it high
// Notes: the bench pulls the line low to stand in for another reset source
`timescale 1ns/1ps
`default_nettype none
module hwm_board (
  input wire logic reset_pin_oe,
  input wire logic reset_pin_o,
  input wire logic ext_pull_low,
  input wire logic intrude,
  output logic reset_line,
  output logic chassis_intrusion
);
  // wired-and of both pull-downs, pull-up otherwise
  assign reset_line = ((reset_pin_oe && !reset_pin_o) || ext_pull_low) ? 1'b0 : 1'b1;
  // detector reports an intrusion as a high level
  assign chassis_intrusion = intrude;
endmodule : hwm_board
`default_nettype wire

//--- hwm_pkg.sv
// Purpose: shared constants and types of the hardware monitor alert and reset logic
// Assumes: 125 MHz hclk, AHB-Lite register access, word registers at index * 4
// Notes: register indices, bit positions and setpoint resets are our own choices
// Contract
// RQ1: one-time mode interrupts latch until status-1 read
// RQ2: critical alarm latches until extended-1 read
// RQ3: low interrupt at or below low, rearm above low+hyst
// RQ4: high interrupt above high, rearm at high-hyst
// RQ5: critical above setpoint, rearm at critical-hyst
// RQ6: comparator low interrupt, released above low+hyst
// RQ7: comparator high interrupt, released at high-hyst
// RQ8: comparator critical alarm, released at critical-hyst
// RQ9: intrusion detector drives active-high input
// RQ10: sources in two status registers, two masks
// RQ11: configuration bit enables alert output
// RQ12: critical alarm only from temperature, extended-1
// RQ13: status read returns contents, then clears
// RQ14: status clear releases alert until next update
// RQ15: software spaces status reads 820 ms apart
// RQ16: configuration bit 3 releases alert, halts loop
// RQ17: reset output only when mask-2 bit 7
// RQ18: configuration bit 4 gives 20 ms low, self-clears
// RQ19: low reset input restores register defaults
// RQ20: tree test entry only before first configuration write
// RQ21: tree result toggles per included pin pulled low
// RQ22: setpoints are 8-bit two's complement degrees
// RQ23: hysteresis is unsigned 3-bit degrees
// RQ24: comparisons evaluated once per finished conversion
package hwm_pkg;
  // register indices, byte address is index * 4
  localparam logic [7:0] IDX_CFG = 8'h40;
  localparam logic [7:0] IDX_STAT1 = 8'h41;
  localparam logic [7:0] IDX_STAT2 = 8'h42;
  localparam logic [7:0] IDX_MASK1 = 8'h43;
  localparam logic [7:0] IDX_MASK2 = 8'h44;
  localparam logic [7:0] IDX_EXT1 = 8'h4c;
  localparam logic [7:0] IDX_EXT2 = 8'h4d;
  localparam logic [7:0] IDX_HIGH_TEMP_SETPOINT = 8'h50;
  localparam logic [7:0] IDX_LOW_TEMP_SETPOINT = 8'h51;
  localparam logic [7:0] IDX_TCRIT = 8'h52;
  localparam logic [7:0] IDX_HYSTERESIS_OFFSET = 8'h53;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // reset values
  localparam logic [7:0] CFG_RST = 8'h08;
  localparam logic [7:0] EXT1_RST = 8'h44;
  localparam logic [7:0] EXT2_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] HIGH_TEMP_SETPOINT_RST = 8'h50;
  localparam logic [7:0] LOW_TEMP_SETPOINT_RST = 8'h00;
  localparam logic [7:0] TCRIT_RST = 8'h64;
  localparam logic [2:0] HYSTERESIS_OFFSET_RST = 3'h2;

  // field positions
  localparam int CFG_INT_EN_BIT = 1;
  localparam int CFG_INT_CLR_BIT = 3;
  localparam int CFG_RST_OUT_BIT = 4;
  localparam int MASK2_RST_EN_BIT = 7;
  localparam int STAT1_TEMP_BIT = 4;
  localparam int STAT2_CHASSIS_BIT = 4;
  localparam int EXT1_CRIT_BIT = 0;
  localparam int EXT2_MODE_BIT = 0;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_PULSE_MS = 20;
  localparam int RST_PULSE_CYC = (RST_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 22;
  localparam logic [2:0] RST_BLANK_CYC = 3'h6;

  // board test
  localparam int NTREE = 16;

  typedef enum logic {
    HWM_ONE_TIME,
    HWM_COMPARATOR
  } hwm_tmode_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] crit;
    logic [2:0] hyst;
  } hwm_limits_t;
endpackage : hwm_pkg
